// ==== rtl/lcd_regs_consts.svh ====
// Register numbers, field positions, reset values and timing counts of the LCD register file.
`ifndef LCD_REGS_CONSTS_SVH
`define LCD_REGS_CONSTS_SVH

// Data register numbers.
`define IDX_HTOTAL 5'h00
`define IDX_HDISP 5'h01
`define IDX_RPR 5'h09
`define IDX_CSTART 5'h0A
`define IDX_CEND 5'h0B
`define IDX_SADDR_HI 5'h0C
`define IDX_SADDR_LO 5'h0D
`define IDX_CADDR_HI 5'h0E
`define IDX_CADDR_LO 5'h0F
`define IDX_VWIDTH 5'h12
`define IDX_VDOTS_HI 5'h13
`define IDX_VDOTS_LO 5'h14
`define IDX_TOPRAST 5'h15
`define IDX_MODE 5'h16

// Field positions.
`define RASTER_MSB 4
`define CMODE_LSB 5
`define CMODE_MSB 6
`define MODE_ATTR 0
`define MODE_BLINK 1
`define MODE_WIDE 2
`define MODE_GRAPHIC 3
`define MODE_ON 4

// Reset values.
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000
`define RST_RASTER 5'h00

// Character widths in dots.
`define DOTS_NARROW 5'h08
`define DOTS_WIDE 5'h10

// Blink period bits of the frame counter: 32 and 64 frames.
`define BLINK32_BIT 4
`define BLINK64_BIT 5

`endif

// ==== rtl/lcd_regs_pkg.sv ====
// Types shared by the LCD register file.
package lcd_regs_pkg;
  typedef logic [4:0] reg_index_t;
  typedef logic [7:0] byte_t;
  typedef enum logic [1:0] {cursor_steady, cursor_off, cursor_blink32, cursor_blink64} cursor_mode_e;
endpackage : lcd_regs_pkg

// ==== rtl/row_address_gen.sv ====
// Row start address generator stepping by the virtual row width.
`timescale 1ns/10ps
`include "lcd_regs_consts.svh"
module row_address_gen (
  // Clock and reset.
  input wire logic mclk_in,
  input wire logic rst_in,
  // Timing strobes from the scan logic.
  input wire logic frame_start_in,
  input wire logic row_next_in,
  // Programmed values.
  input wire logic [15:0] start_addr_in,
  input wire logic [7:0] virtual_width_in,
  // Start address of the current row.
  output logic [15:0] row_addr_out
);

  // A frame restarts at the programmed origin, so a rewrite of the start address moves the page.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      row_addr_out <= `RST_WORD;
    end else if (frame_start_in) begin
      row_addr_out <= start_addr_in;
    end else if (row_next_in) begin
      row_addr_out <= 16'(row_addr_out + {8'h00, virtual_width_in});
    end
  end

  chk_row_step: assert property (@(posedge mclk_in) disable iff (rst_in)
    row_next_in && !frame_start_in |=> row_addr_out ==
      16'($past(row_addr_out) + {8'h00, $past(virtual_width_in)}))
    else $error("Row start did not advance by the virtual width.");

  chk_frame_origin: assert property (@(posedge mclk_in) disable iff (rst_in)
    frame_start_in |=> row_addr_out == $past(start_addr_in))
    else $error("Frame did not restart at the start address.");

endmodule : row_address_gen

// ==== rtl/lcd_register_file.sv ====
// Host-programmable register file of the LCD timing controller.
`timescale 1ns/10ps
`include "lcd_regs_consts.svh"
module lcd_register_file (
  // Clock and reset.
  input wire logic mclk_in,
  input wire logic rst_in,
  // Host bus pins, asynchronous to mclk_in.
  input wire logic cs_n_in,
  input wire logic rd_n_in,
  input wire logic wr_n_in,
  input wire logic register_select_in,
  input wire logic [7:0] db_in,
  output logic [7:0] db_out,
  output logic db_oe_out,
  // External mode pins, asynchronous.
  input wire logic display_on_pin_in,
  input wire logic graphic_pin_in,
  input wire logic wide_pin_in,
  input wire logic blink_enable_bit_pin_in,
  input wire logic attribute_pin_in,
  // Scan timing from the display timing logic.
  input wire logic frame_start_in,
  input wire logic row_next_in,
  input wire logic [4:0] raster_in,
  input wire logic [15:0] mem_addr_in,
  // Programmed values for the timing logic.
  output logic [7:0] htotal_out,
  output logic [7:0] hdisp_out,
  output logic [4:0] max_line_in_row_out,
  output logic [15:0] vdots_out,
  output logic [4:0] top_raster_out,
  output logic [15:0] row_addr_out,
  output logic [4:0] char_dots_out,
  // Effective display mode.
  output logic display_on_out,
  output logic graphic_out,
  output logic wide_out,
  output logic blink_enable_bit_out,
  output logic attribute_out,
  // Cursor marker for the current character.
  output logic cursor_display_output
);

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  logic [8:0] pin_s1_q;
  logic [8:0] pin_s2_q;
  logic [7:0] db_s1_q;
  logic [7:0] db_s2_q;
  logic wr_n_s3_q;
  logic rd_n_s3_q;

  // Bus strobes, select and mode pins all come from outside the clock domain.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_s1_q <= 9'h007;
      pin_s2_q <= 9'h007;
      db_s1_q <= `RST_BYTE;
      db_s2_q <= `RST_BYTE;
    end else begin
      // Mode pins sit in the same bit order as the mode register, so the OR needs no shuffle.
      pin_s1_q <= {display_on_pin_in, graphic_pin_in, wide_pin_in, blink_enable_bit_pin_in,
                   attribute_pin_in, register_select_in, rd_n_in, wr_n_in, cs_n_in};
      pin_s2_q <= pin_s1_q;
      db_s1_q <= db_in;
      db_s2_q <= db_s1_q;
    end
  end

  // Third stage keeps the previous strobe level for edge detection.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_n_s3_q <= 1'b1;
      rd_n_s3_q <= 1'b1;
    end else begin
      wr_n_s3_q <= pin_s2_q[1];
      rd_n_s3_q <= pin_s2_q[2];
    end
  end

  logic cs_n_s;
  logic rd_n_s;
  logic rs_s;
  logic [4:0] mode_pins_s;
  logic wr_done;
  logic idx_wr;
  logic data_wr;
  logic rd_active;
  assign cs_n_s = pin_s2_q[0];
  assign rd_n_s = pin_s2_q[2];
  assign rs_s = pin_s2_q[3];
  assign mode_pins_s = pin_s2_q[8:4];
  // A write takes effect on the rising edge of the write strobe, when the data is settled.
  assign wr_done = pin_s2_q[1] && !wr_n_s3_q && !cs_n_s;
  assign idx_wr = wr_done && !rs_s;
  assign data_wr = wr_done && rs_s;
  assign rd_active = !rd_n_s && !cs_n_s && rs_s;

  ////////////////////////////////////////////////////////////////////////////////
  // Register decode.

  // Only fourteen numbers map to storage; the legacy timing numbers fall through.
  function automatic logic idx_valid(input lcd_regs_pkg::reg_index_t idx);
    if (idx == `IDX_HTOTAL || idx == `IDX_HDISP) begin
      idx_valid = 1'b1;
    end else if (idx >= `IDX_RPR && idx <= `IDX_CADDR_LO) begin
      idx_valid = 1'b1;
    end else if (idx >= `IDX_VWIDTH && idx <= `IDX_MODE) begin
      idx_valid = 1'b1;
    end else begin
      idx_valid = 1'b0;
    end
  endfunction : idx_valid

  lcd_regs_pkg::reg_index_t index_q;
  logic [6:0] cstart_q;
  logic [4:0] cend_q;
  logic [15:0] saddr_q;
  logic [15:0] caddr_q;
  logic [7:0] vwidth_q;
  logic [4:0] mode_q;

  // Index register: bits above the register number are not stored.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      index_q <= `RST_RASTER;
    end else if (idx_wr) begin
      index_q <= db_s2_q[4:0];
    end
  end

  // Data registers; a write through an unknown number changes nothing.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      htotal_out <= `RST_BYTE;
      hdisp_out <= `RST_BYTE;
      max_line_in_row_out <= `RST_RASTER;
      cstart_q <= 7'h00;
      cend_q <= `RST_RASTER;
      saddr_q <= `RST_WORD;
      caddr_q <= `RST_WORD;
      vwidth_q <= `RST_BYTE;
      vdots_out <= `RST_WORD;
      top_raster_out <= `RST_RASTER;
      mode_q <= `RST_RASTER;
    end else if (data_wr && idx_valid(index_q)) begin
      if (index_q == `IDX_HTOTAL) begin
        htotal_out <= db_s2_q;
      end else if (index_q == `IDX_HDISP) begin
        hdisp_out <= db_s2_q;
      end else if (index_q == `IDX_RPR) begin
        max_line_in_row_out <= db_s2_q[`RASTER_MSB:0];
      end else if (index_q == `IDX_CSTART) begin
        cstart_q <= db_s2_q[`CMODE_MSB:0];
      end else if (index_q == `IDX_CEND) begin
        cend_q <= db_s2_q[`RASTER_MSB:0];
      end else if (index_q == `IDX_SADDR_HI) begin
        saddr_q[15:8] <= db_s2_q;
      end else if (index_q == `IDX_SADDR_LO) begin
        saddr_q[7:0] <= db_s2_q;
      end else if (index_q == `IDX_CADDR_HI) begin
        caddr_q[15:8] <= db_s2_q;
      end else if (index_q == `IDX_CADDR_LO) begin
        caddr_q[7:0] <= db_s2_q;
      end else if (index_q == `IDX_VWIDTH) begin
        vwidth_q <= db_s2_q;
      end else if (index_q == `IDX_VDOTS_HI) begin
        vdots_out[15:8] <= db_s2_q;
      end else if (index_q == `IDX_VDOTS_LO) begin
        vdots_out[7:0] <= db_s2_q;
      end else if (index_q == `IDX_TOPRAST) begin
        top_raster_out <= db_s2_q[`RASTER_MSB:0];
      end else begin
        mode_q <= db_s2_q[`MODE_ON:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Host reads.

  // Only the cursor address answers; write-only numbers return zero, unknown ones stay off the bus.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      db_out <= `RST_BYTE;
      db_oe_out <= 1'b0;
    end else if (rd_active && idx_valid(index_q)) begin
      db_oe_out <= 1'b1;
      if (index_q == `IDX_CADDR_HI) begin
        db_out <= caddr_q[15:8];
      end else if (index_q == `IDX_CADDR_LO) begin
        db_out <= caddr_q[7:0];
      end else begin
        db_out <= `RST_BYTE;
      end
    end else begin
      db_out <= `RST_BYTE;
      db_oe_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Effective mode and character width.

  logic [4:0] eff_mode;
  assign eff_mode = mode_q | mode_pins_s;

  // Registered so every mode output comes from a flip-flop.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      display_on_out <= 1'b0;
      graphic_out <= 1'b0;
      wide_out <= 1'b0;
      blink_enable_bit_out <= 1'b0;
      attribute_out <= 1'b0;
      char_dots_out <= `DOTS_NARROW;
    end else begin
      display_on_out <= eff_mode[`MODE_ON];
      graphic_out <= eff_mode[`MODE_GRAPHIC];
      wide_out <= eff_mode[`MODE_WIDE];
      blink_enable_bit_out <= eff_mode[`MODE_BLINK];
      attribute_out <= eff_mode[`MODE_ATTR];
      // Wide and graphic characters use sixteen dots per character cell.
      if (eff_mode[`MODE_WIDE] || eff_mode[`MODE_GRAPHIC]) begin
        char_dots_out <= `DOTS_WIDE;
      end else begin
        char_dots_out <= `DOTS_NARROW;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Cursor.

  logic [5:0] frame_cnt_q;
  lcd_regs_pkg::cursor_mode_e cmode;
  logic cursor_visible;
  assign cmode = lcd_regs_pkg::cursor_mode_e'(cstart_q[`CMODE_MSB:`CMODE_LSB]);

  // Frame counter for the blink phases; it free-runs, so the phase is not tied to writes.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      frame_cnt_q <= 6'h00;
    end else if (frame_start_in) begin
      frame_cnt_q <= 6'(frame_cnt_q + 6'h01);
    end
  end

  always_comb begin
    case (cmode)
      lcd_regs_pkg::cursor_steady: cursor_visible = 1'b1;
      lcd_regs_pkg::cursor_off: cursor_visible = 1'b0;
      lcd_regs_pkg::cursor_blink32: cursor_visible = !frame_cnt_q[`BLINK32_BIT];
      default: cursor_visible = !frame_cnt_q[`BLINK64_BIT];
    endcase
  end

  // Marker for the character at the cursor address on rasters between start and end.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      cursor_display_output <= 1'b0;
    end else begin
      cursor_display_output <= cursor_visible && mem_addr_in == caddr_q
        && raster_in >= cstart_q[`RASTER_MSB:0] && raster_in <= cend_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Row addressing.

  row_address_gen u_row_gen (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .frame_start_in(frame_start_in),
    .row_next_in(row_next_in),
    .start_addr_in(saddr_q),
    .virtual_width_in(vwidth_q),
    .row_addr_out(row_addr_out)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  chk_index_load: assert property (@(posedge mclk_in) disable iff (rst_in)
    idx_wr |=> index_q == $past(db_s2_q[4:0]))
    else $error("Index not loaded by select-low write.");

  chk_invalid_write: assert property (@(posedge mclk_in) disable iff (rst_in)
    data_wr && !idx_valid(index_q) |=> $stable({htotal_out, hdisp_out, saddr_q, caddr_q,
      vdots_out, mode_q, cstart_q, cend_q, vwidth_q, top_raster_out, max_line_in_row_out}))
    else $error("Write through an invalid number changed a register.");

  chk_total_write: assert property (@(posedge mclk_in) disable iff (rst_in)
    data_wr && index_q == `IDX_HTOTAL |=> htotal_out == $past(db_s2_q))
    else $error("Horizontal total not written.");

  chk_row_height: assert property (@(posedge mclk_in) disable iff (rst_in)
    data_wr && index_q == `IDX_RPR |=> max_line_in_row_out == $past(db_s2_q[4:0]))
    else $error("Row height field not written.");

  chk_cursor_off: assert property (@(posedge mclk_in) disable iff (rst_in)
    cmode == lcd_regs_pkg::cursor_off |=> !cursor_display_output)
    else $error("Cursor shown while switched off.");

  chk_cursor_read: assert property (@(posedge mclk_in) disable iff (rst_in)
    rd_active && index_q == `IDX_CADDR_LO |=> db_oe_out && db_out == $past(caddr_q[7:0]))
    else $error("Cursor address low byte not returned.");

  chk_unknown_read: assert property (@(posedge mclk_in) disable iff (rst_in)
    rd_active && !idx_valid(index_q) |=> !db_oe_out)
    else $error("Read through an invalid number drove the bus.");

  chk_wo_read: assert property (@(posedge mclk_in) disable iff (rst_in)
    rd_active && index_q == `IDX_HTOTAL |=> db_oe_out && db_out == `RST_BYTE)
    else $error("Write-only register leaked its value.");

  chk_mode_or: assert property (@(posedge mclk_in) disable iff (rst_in)
    ##1 {display_on_out, graphic_out, wide_out, blink_enable_bit_out, attribute_out}
      == ($past(mode_q) | $past(mode_pins_s)))
    else $error("Effective mode is not the OR of register and pins.");

  cov_index_then_data: cover property (@(posedge mclk_in) disable iff (rst_in)
    idx_wr ##[1:50] data_wr);
  cov_cursor_read: cover property (@(posedge mclk_in) disable iff (rst_in)
    rd_active && index_q == `IDX_CADDR_HI);
  cov_cursor_hit: cover property (@(posedge mclk_in) disable iff (rst_in)
    cursor_display_output);

endmodule : lcd_register_file

// ==== verif/lcd_host_model.sv ====
// Host processor model that drives the register file's parallel bus.
`timescale 1ns/10ps
module lcd_host_model (
  // Clock.
  input wire logic mclk_in,
  // Bus towards the device.
  output logic cs_n_out,
  output logic rd_n_out,
  output logic wr_n_out,
  output logic register_select_out,
  output logic [7:0] db_out,
  // Read answer from the device.
  input wire logic [7:0] db_in,
  input wire logic db_oe_in
);
  // The bus idles deselected from time zero.
  initial begin
    cs_n_out = 1'b1;
    rd_n_out = 1'b1;
    wr_n_out = 1'b1;
    register_select_out = 1'b0;
    db_out = 8'h00;
  end

  //////////////////////////////////////////////////////////////////////////////
  // One write cycle; select low addresses the index, high the data register.
  task automatic bus_write(input logic rs, input logic [7:0] data);
    @(posedge mclk_in);
    cs_n_out <= 1'b0;
    register_select_out <= rs;
    db_out <= data;
    wr_n_out <= 1'b0;
    repeat (4) @(posedge mclk_in);
    wr_n_out <= 1'b1;
    repeat (4) @(posedge mclk_in);
    cs_n_out <= 1'b1;
    db_out <= ~data; // A released bus must not keep showing the old byte.
    repeat (3) @(posedge mclk_in);
  endtask : bus_write

  // One read cycle of the indexed data register, bounded wait for the drive.
  task automatic bus_read(output logic [7:0] data, output logic oe);
    int n;
    @(posedge mclk_in);
    cs_n_out <= 1'b0;
    rd_n_out <= 1'b0;
    register_select_out <= 1'b1;
    n = 0;
    oe = 1'b0;
    data = 8'h00;
    while (n < 12 && oe !== 1'b1) begin
      @(posedge mclk_in);
      n++;
      if (db_oe_in === 1'b1) begin
        oe = 1'b1;
        data = db_in;
      end
    end
    rd_n_out <= 1'b1;
    cs_n_out <= 1'b1;
    repeat (5) @(posedge mclk_in);
  endtask : bus_read
endmodule : lcd_host_model

// ==== verif/lcd_register_file_bench.sv ====
// Self-checking bench of the LCD register file.
`timescale 1ns/10ps
`include "lcd_regs_consts.svh"
module lcd_register_file_bench;
  logic mclk_in, rst_in, cs_n, rd_n, wr_n, rs, db_oe, cursor_q, frame_start, row_next;
  logic [7:0] db_to_dut, db_from_dut, htotal, hdisp, d;
  logic [4:0] pins, max_line, top_raster, dots, raster, mode_now;
  logic [15:0] vdots, row_addr, mem_addr;
  logic oe;
  int fail_count, comparisons;

  lcd_host_model host (.mclk_in(mclk_in), .cs_n_out(cs_n), .rd_n_out(rd_n), .wr_n_out(wr_n),
    .register_select_out(rs), .db_out(db_to_dut), .db_in(db_from_dut), .db_oe_in(db_oe));

  lcd_register_file DUT (.mclk_in(mclk_in), .rst_in(rst_in), .cs_n_in(cs_n), .rd_n_in(rd_n),
    .wr_n_in(wr_n), .register_select_in(rs), .db_in(db_to_dut), .db_out(db_from_dut),
    .db_oe_out(db_oe), .display_on_pin_in(pins[4]), .graphic_pin_in(pins[3]),
    .wide_pin_in(pins[2]), .blink_enable_bit_pin_in(pins[1]), .attribute_pin_in(pins[0]),
    .frame_start_in(frame_start), .row_next_in(row_next), .raster_in(raster),
    .mem_addr_in(mem_addr), .htotal_out(htotal), .hdisp_out(hdisp),
    .max_line_in_row_out(max_line), .vdots_out(vdots), .top_raster_out(top_raster),
    .row_addr_out(row_addr), .char_dots_out(dots), .display_on_out(mode_now[4]),
    .graphic_out(mode_now[3]), .wide_out(mode_now[2]), .blink_enable_bit_out(mode_now[1]),
    .attribute_out(mode_now[0]), .cursor_display_output(cursor_q));

  //////////////////////////////////////////////////////////////////////////////
  // Clock of 8 ns.
  initial begin
    mclk_in = 1'b0;
    forever #4 mclk_in = ~mclk_in;
  end

  // Counts a comparison and reports a mismatch.
  task automatic check(input string name, input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // Index write followed by a data write or read.
  task automatic wr(input logic [4:0] idx, input logic [7:0] val);
    host.bus_write(1'b0, {3'b000, idx});
    host.bus_write(1'b1, val);
  endtask : wr

  task automatic rd(input logic [4:0] idx);
    host.bus_write(1'b0, {3'b000, idx});
    host.bus_read(d, oe);
  endtask : rd

  // One-cycle scan strobe, frame start when f is high, next row otherwise.
  task automatic pulse(input logic f);
    frame_start <= f;
    row_next <= !f;
    @(posedge mclk_in);
    frame_start <= 1'b0;
    row_next <= 1'b0;
    @(posedge mclk_in);
  endtask : pulse

  // Steps the cursor through its four display modes.
  task automatic cursor_modes(input logic [3:0] vis);
    for (int i = 0; i < 4; i++) begin
      wr(`IDX_CSTART, {1'b0, 2'(i), 5'h02});
      repeat (3) @(posedge mclk_in);
      check("cursor_mode", 16'(cursor_q), 16'(vis[i]));
    end
  endtask : cursor_modes

  task stop_test;
    if (fail_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test

  //////////////////////////////////////////////////////////////////////////////
  // Watchdog well beyond the expected couple of thousand cycles.
  initial begin
    #(20000 * 8);
    fail_count++;
    stop_test();
  end

  // Main sequence.
  initial begin
    logic [4:0] bad [10];
    bad = '{5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h10, 5'h11, 5'h1F};
    rst_in = 1'b1;
    pins = 5'h00;
    frame_start = 1'b0;
    row_next = 1'b0;
    raster = 5'h00;
    mem_addr = 16'h0000;
    repeat (6) @(posedge mclk_in);
    rst_in <= 1'b0;
    @(posedge mclk_in);
    check("reset_dots", 16'(dots), 16'h0008);
    // Timing values chosen to satisfy the software-side limits.
    wr(`IDX_HTOTAL, 8'h4F);
    wr(`IDX_HDISP, 8'h40);
    wr(`IDX_RPR, 8'hFF);
    wr(`IDX_VDOTS_HI, 8'h00);
    wr(`IDX_VDOTS_LO, 8'hC7);
    wr(`IDX_TOPRAST, 8'h07);
    check("htotal", 16'(htotal), 16'h004F);
    check("hdisp", 16'(hdisp), 16'h0040);
    check("max_line", 16'(max_line), 16'h001F);
    check("vdots", vdots, 16'h00C7);
    check("top_raster", 16'(top_raster), 16'h0007);
    // Numbers without a data register take no write and give no read.
    for (int i = 0; i < 10; i++) begin
      wr(bad[i], 8'hAA);
      rd(bad[i]);
      check("bad_oe", 16'(oe), 16'h0000);
    end
    check("htotal_kept", 16'(htotal), 16'h004F);
    check("hdisp_kept", 16'(hdisp), 16'h0040);
    // Cursor address reads back; other registers read as zero.
    wr(`IDX_CADDR_HI, 8'h12);
    wr(`IDX_CADDR_LO, 8'h34);
    rd(`IDX_CADDR_HI);
    check("caddr_hi", {7'h00, oe, d}, 16'h0112);
    rd(`IDX_CADDR_LO);
    check("caddr_lo", {7'h00, oe, d}, 16'h0134);
    rd(`IDX_HTOTAL);
    check("wo_read", 16'(d), 16'h0000);
    // Every mode bit from the register and from its pin.
    for (int i = 0; i < 5; i++) begin
      wr(`IDX_MODE, 8'h01 << i);
      check("mode_reg", 16'(mode_now), 16'(5'h01 << i));
      check("dots", 16'(dots), (i == 2 || i == 3) ? 16'h0010 : 16'h0008);
      wr(`IDX_MODE, 8'h00);
      // One pin at a time from all-low, and all-low restored after, keeps the pins legal.
      pins <= 5'h01 << i;
      repeat (4) @(posedge mclk_in);
      check("mode_pin", 16'(mode_now), 16'(5'h01 << i));
      pins <= 5'h00;
      repeat (4) @(posedge mclk_in);
    end
    // Row addresses step by the virtual width; a new start pages the display.
    wr(`IDX_SADDR_HI, 8'h01);
    wr(`IDX_SADDR_LO, 8'h00);
    wr(`IDX_VWIDTH, 8'h40);
    pulse(1'b1);
    check("row_first", row_addr, 16'h0100);
    pulse(1'b0);
    pulse(1'b0);
    check("row_third", row_addr, 16'h0180);
    wr(`IDX_SADDR_HI, 8'h02);
    pulse(1'b1);
    check("row_page", row_addr, 16'h0200);
    // Cursor window rasters 2 to 5 at address 1234.
    wr(`IDX_CEND, 8'h05);
    wr(`IDX_CSTART, 8'h02);
    mem_addr <= 16'h1234;
    raster <= 5'h02;
    repeat (3) @(posedge mclk_in);
    check("cursor_first", 16'(cursor_q), 16'h0001);
    raster <= 5'h06;
    repeat (3) @(posedge mclk_in);
    check("cursor_past", 16'(cursor_q), 16'h0000);
    raster <= 5'h05;
    repeat (3) @(posedge mclk_in);
    check("cursor_last", 16'(cursor_q), 16'h0001);
    // Two frames seen so far, then eighteen: each blink rate shows its phase.
    cursor_modes(4'b1101);
    repeat (16) pulse(1'b1);
    cursor_modes(4'b1001);
    stop_test();
  end
endmodule : lcd_register_file_bench
